// ===== pcs_top.sv
// Behaviour
// RULE1: Reserved bits of both registers read zero and ignore writes.
// RULE2: Stable flag reads 0 until the oscillator counter reaches 41,032 cycles.
// RULE3: Stable reads 1 if counter done, counter disabled or test mode; resets 1.
// RULE4: Lock flag reads 0 while acquiring, 1 once phase lock achieved.
// RULE5: Loop reset bit, reset 1, holds the PLL in reset while set.
// RULE6: Oscillator power-down bit, reset 0, powers oscillator down per mode bit.
// RULE7: With mode bit 0, oscillator powers down only once clock generator idles.
// RULE8: With mode bit 1, oscillator powers down immediately when requested.
// RULE9: Loop power-down bit, reset 0, places the PLL in power-down when 1.
// RULE10: Mode enable 0 bypasses PLL and first divider; clocks from reference.
// RULE11: Mode enable 1 derives all three system clocks from the PLL output.
// RULE12: Five-bit multiplier resets 0; codes 2 to 15 multiply, others reserved.
// RULE13: Software reprograms: bypass, reset, change, wait 1 us, release, lock, enable.
// RULE14: Control/status register at 1C80h, multiplier register at 1C88h.
// RULE15: Lock flag clears on PLL reset or power-down until a new lock.
// RULE16: Status flags are synchronised into the register clock domain before reading; only lock has a two-flop synchroniser here, stable is registered once.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"

module pcs_top
  import pcs_pkg::*;
#(
  parameter int OSC_STABLE_CYCLES = `PCS_OSC_STABLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic clock_mode_select_bit,
  input wire logic clockgen_idle_status,
  input wire logic osc_counter_disable,
  input wire logic test_mode,
  input wire logic pll_lock_raw,
  output logic loop_reset_ctl,
  output logic loop_powerdown_ctl,
  output logic osc_powerdown_ctl,
  output logic osc_powerdown,
  output logic loop_mode_enable,
  output logic [4:0] multiplier_field
);

  pcs_stat_if st ();
  pcs_word_t rdata_next;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
    addr_hit = (addr == target);
  endfunction

  // ----------------------------------------------------------------------
  // Control/status register, writable fields
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      loop_reset_ctl <= `PCS_RST_RESET;
      osc_powerdown_ctl <= `PCS_OSCPD_RESET;
      loop_powerdown_ctl <= `PCS_PLLPD_RESET;
      loop_mode_enable <= `PCS_MODE_RESET;
    end else if (io_wr && addr_hit(io_addr, `PCS_CSR_ADDR)) begin // RULE14
      loop_reset_ctl <= io_wdata[`PCS_RST_BIT]; // RULE5
      osc_powerdown_ctl <= io_wdata[`PCS_OSCPD_BIT]; // RULE6
      loop_powerdown_ctl <= io_wdata[`PCS_PLLPD_BIT]; // RULE9
      loop_mode_enable <= io_wdata[`PCS_MODE_BIT]; // RULE10 RULE11
    end
  end

  // ----------------------------------------------------------------------
  // Multiplier register
  // ----------------------------------------------------------------------
  // Reserved codes are stored as written; keeping them out is software's job.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      multiplier_field <= `PCS_MUL_RESET; // RULE12
    end else if (io_wr && addr_hit(io_addr, `PCS_MUL_ADDR)) begin // RULE14
      multiplier_field <= io_wdata[`PCS_MUL_MSB:0]; // RULE12 RULE1
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator power-down
  // ----------------------------------------------------------------------
  // Once down in idle-gated mode it stays down until the request is dropped,
  // so a brief exit from idle does not restart the oscillator mid-sequence.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      osc_powerdown <= 1'b0;
    end else if (!osc_powerdown_ctl) begin
      osc_powerdown <= 1'b0; // RULE6
    end else if (clock_mode_select_bit) begin
      osc_powerdown <= 1'b1; // RULE8
    end else if (clockgen_idle_status) begin
      osc_powerdown <= 1'b1; // RULE7
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  assign st.osc_pd = osc_powerdown;
  assign st.pll_hold = loop_reset_ctl | loop_powerdown_ctl; // RULE15
  assign st.lock_raw = pll_lock_raw;
  assign st.cnt_dis = osc_counter_disable;
  assign st.test_mode = test_mode;

  pcs_status_mon #(
    .OSC_STABLE_CYCLES(OSC_STABLE_CYCLES)
  ) u_status_mon (
    .sys_clk(sys_clk),
    .reset(reset),
    .st(st)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_next = 16'h0000; // RULE1
    if (io_rd && addr_hit(io_addr, `PCS_CSR_ADDR)) begin
      rdata_next[`PCS_STABLE_BIT] = st.stable; // RULE2 RULE3
      rdata_next[`PCS_LOCK_BIT] = st.lock; // RULE4
      rdata_next[`PCS_RST_BIT] = loop_reset_ctl;
      rdata_next[`PCS_OSCPD_BIT] = osc_powerdown_ctl;
      rdata_next[`PCS_PLLPD_BIT] = loop_powerdown_ctl;
      rdata_next[`PCS_MODE_BIT] = loop_mode_enable;
    end else if (io_rd && addr_hit(io_addr, `PCS_MUL_ADDR)) begin
      rdata_next[`PCS_MUL_MSB:0] = multiplier_field;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      io_rdata <= 16'h0000;
    end else begin
      io_rdata <= rdata_next;
    end
  end

endmodule // pcs_top

`default_nettype wire

// ===== pcs_cfg.svh
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ----------------------------------------------------------------------
// Register word addresses in the I/O space
// ----------------------------------------------------------------------
`define PCS_CSR_ADDR 16'h1c80
`define PCS_MUL_ADDR 16'h1c88

// ----------------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------------
`define PCS_STABLE_BIT 6
`define PCS_LOCK_BIT 5
`define PCS_RST_BIT 3
`define PCS_OSCPD_BIT 2
`define PCS_PLLPD_BIT 1
`define PCS_MODE_BIT 0
`define PCS_MUL_MSB 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCS_RST_RESET 1'b1
`define PCS_OSCPD_RESET 1'b0
`define PCS_PLLPD_RESET 1'b0
`define PCS_MODE_RESET 1'b0
`define PCS_MUL_RESET 5'h00
`define PCS_STABLE_RESET 1'b1
`define PCS_LOCK_RESET 1'b0

// ----------------------------------------------------------------------
// Timing counts, in reference clock cycles
// ----------------------------------------------------------------------
`define PCS_OSC_STABLE_CYCLES 41032

`endif

// ===== pcs_pkg.sv
package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_OSC_READY,
    PCS_OSC_DOWN,
    PCS_OSC_WARMUP
  } pcs_osc_state_t;

  typedef logic [15:0] pcs_word_t;

endpackage

// ===== pcs_stat_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pcs_stat_if;
  logic osc_pd;
  logic pll_hold;
  logic lock_raw;
  logic cnt_dis;
  logic test_mode;
  logic stable;
  logic lock;

  modport regs (output osc_pd, output pll_hold, output lock_raw, output cnt_dis,
                output test_mode, input stable, input lock);
  modport mon (input osc_pd, input pll_hold, input lock_raw, input cnt_dis,
               input test_mode, output stable, output lock);
endinterface

`default_nettype wire

// ===== pcs_status_mon.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"

module pcs_status_mon
  import pcs_pkg::*;
#(
  parameter int OSC_STABLE_CYCLES = `PCS_OSC_STABLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  pcs_stat_if.mon st
);

  pcs_osc_state_t osc_state_reg;
  logic [15:0] osc_cnt_reg;
  logic lock_sync1_reg;
  logic lock_sync2_reg;
  logic relock_wait_reg;
  logic stable_reg;
  logic lock_reg;

  localparam logic [15:0] OSC_LAST = 16'(OSC_STABLE_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Oscillator start-up counter
  // ----------------------------------------------------------------------
  // The oscillator is taken as settled at reset release; the count only runs
  // after it wakes from power-down.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      osc_state_reg <= PCS_OSC_READY;
      osc_cnt_reg <= 16'h0000;
    end else begin
      case (osc_state_reg)
        PCS_OSC_READY: begin
          if (st.osc_pd) begin
            osc_state_reg <= PCS_OSC_DOWN;
          end
        end
        PCS_OSC_DOWN: begin
          osc_cnt_reg <= 16'h0000;
          if (!st.osc_pd) begin
            osc_state_reg <= PCS_OSC_WARMUP;
          end
        end
        PCS_OSC_WARMUP: begin
          if (st.osc_pd) begin
            osc_state_reg <= PCS_OSC_DOWN;
          end else if (osc_cnt_reg == OSC_LAST) begin
            osc_state_reg <= PCS_OSC_READY; // RULE2
          end else begin
            osc_cnt_reg <= osc_cnt_reg + 16'h0001;
          end
        end
        default: begin
          osc_state_reg <= PCS_OSC_READY;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stable_reg <= `PCS_STABLE_RESET;
    end else begin
      stable_reg <= st.test_mode | st.cnt_dis | (osc_state_reg == PCS_OSC_READY); // RULE3
    end
  end

  // ----------------------------------------------------------------------
  // Lock indication
  // ----------------------------------------------------------------------
  // The analog lock detector is asynchronous, so it is retimed before use.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lock_sync1_reg <= 1'b0;
      lock_sync2_reg <= 1'b0;
    end else begin
      lock_sync1_reg <= st.lock_raw; // RULE16
      lock_sync2_reg <= lock_sync1_reg; // RULE16
    end
  end

  // A stale lock level from before a reset or power-down must drop once
  // before a new lock is believed.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      relock_wait_reg <= 1'b1;
    end else if (st.pll_hold) begin
      relock_wait_reg <= 1'b1; // RULE15
    end else if (!lock_sync2_reg) begin
      relock_wait_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lock_reg <= `PCS_LOCK_RESET;
    end else begin
      lock_reg <= lock_sync2_reg & !relock_wait_reg & !st.pll_hold; // RULE4 RULE15
    end
  end

  assign st.stable = stable_reg;
  assign st.lock = lock_reg;

endmodule // pcs_status_mon

`default_nettype wire

// ===== pcs_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"
// ----------------------------------------------------------------------
// Register access and power-down relations
// ----------------------------------------------------------------------
module pcs_top_assertions
  import pcs_pkg::*;
#(
  parameter int OSC_STABLE_CYCLES = `PCS_OSC_STABLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  input wire logic clock_mode_select_bit,
  input wire logic clockgen_idle_status,
  input wire logic osc_counter_disable,
  input wire logic test_mode,
  input wire logic pll_lock_raw,
  input wire logic loop_reset_ctl,
  input wire logic loop_powerdown_ctl,
  input wire logic osc_powerdown_ctl,
  input wire logic osc_powerdown,
  input wire logic loop_mode_enable,
  input wire logic [4:0] multiplier_field
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_csr_rd;
    io_rd && io_addr == `PCS_CSR_ADDR;
  endsequence
  sequence s_mul_rd;
    io_rd && io_addr == `PCS_MUL_ADDR;
  endsequence
  a_csr_read_map:
    assert property (s_csr_rd |=> io_rdata[15:7] == 9'h000 && io_rdata[4:0] == {1'b0,
      $past(loop_reset_ctl), $past(osc_powerdown_ctl), $past(loop_powerdown_ctl),
      $past(loop_mode_enable)}) else $error("control read does not match registers");
  a_mul_read_map:
    assert property (s_mul_rd |=> io_rdata == {11'h000, $past(multiplier_field)})
      else $error("multiplier read does not match register");
  a_rdata_idle:
    assert property (!io_rd |=> io_rdata == 16'h0000) else $error("read data without read");
  a_csr_write:
    assert property (io_wr && io_addr == `PCS_CSR_ADDR |=> {loop_reset_ctl, osc_powerdown_ctl,
      loop_powerdown_ctl, loop_mode_enable} == $past(io_wdata[3:0]))
      else $error("control write not applied");
  a_mul_write:
    assert property (io_wr && io_addr == `PCS_MUL_ADDR |=> multiplier_field == $past(io_wdata[4:0]))
      else $error("multiplier write not applied");
  a_osc_immediate:
    assert property (osc_powerdown_ctl && clock_mode_select_bit |=> osc_powerdown)
      else $error("oscillator not powered down at once");
  a_osc_wait_idle:
    assert property (osc_powerdown_ctl && !clock_mode_select_bit && !clockgen_idle_status
      && !osc_powerdown |=> !osc_powerdown) else $error("oscillator down before idle");
  a_osc_release:
    assert property (!osc_powerdown_ctl |=> !osc_powerdown) else $error("oscillator held down");
  a_lock_hold:
    assert property (s_csr_rd ##0 (loop_reset_ctl && $past(loop_reset_ctl)) |=> !io_rdata[5])
      else $error("lock shown while loop held in reset");
  a_stable_forced:
    assert property (s_csr_rd ##0 ($past(test_mode) || $past(osc_counter_disable))
      |=> io_rdata[6]) else $error("stable flag not forced");
endmodule // pcs_top_assertions

bind pcs_top pcs_top_assertions #(.OSC_STABLE_CYCLES(OSC_STABLE_CYCLES)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .clock_mode_select_bit(clock_mode_select_bit),
  .clockgen_idle_status(clockgen_idle_status), .osc_counter_disable(osc_counter_disable),
  .test_mode(test_mode), .pll_lock_raw(pll_lock_raw), .loop_reset_ctl(loop_reset_ctl),
  .loop_powerdown_ctl(loop_powerdown_ctl), .osc_powerdown_ctl(osc_powerdown_ctl),
  .osc_powerdown(osc_powerdown), .loop_mode_enable(loop_mode_enable),
  .multiplier_field(multiplier_field));
`default_nettype wire

// ===== pll_control_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module pll_control_status_regs_tb;
  import pcs_pkg::*;
  localparam logic [15:0] CSR = 16'h1c80;
  localparam logic [15:0] MUL = 16'h1c88;
  logic sys_clk = 1'b0, reset = 1'b1, io_wr = 1'b0, io_rd = 1'b0, cms = 1'b0, idle = 1'b0;
  logic cdis = 1'b0, tmode = 1'b0, raw = 1'b0, lrst, lpd, opc, opd, lme;
  logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000, io_rdata;
  logic [4:0] mf;
  int mismatches = 0, total_checks = 0;
  pcs_top #(.OSC_STABLE_CYCLES(8)) u_dut (.sys_clk(sys_clk), .reset(reset), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .clock_mode_select_bit(cms), .clockgen_idle_status(idle), .osc_counter_disable(cdis),
    .test_mode(tmode), .pll_lock_raw(raw), .loop_reset_ctl(lrst), .loop_powerdown_ctl(lpd),
    .osc_powerdown_ctl(opc), .osc_powerdown(opd), .loop_mode_enable(lme), .multiplier_field(mf));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge sys_clk);
    io_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge sys_clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    #1;
    chk(what, exp, io_rdata);
  endtask
  task automatic t_regs;
    rd(CSR, 16'h0048, "csr reset");
    rd(MUL, 16'h0000, "mul reset");
    wr(CSR, 16'hfff0);
    rd(CSR, 16'h0040, "csr reserved");
    wr(MUL, 16'hffef);
    rd(MUL, 16'h000f, "mul reserved");
    wr(16'h1c82, 16'h001f);
    rd(16'h1c82, 16'h0000, "unmapped");
    for (int c = 2; c < 16; c++) begin
      wr(MUL, 16'(c));
      chk("mul out", 16'(c), {11'h000, mf});
    end
    wr(CSR, 16'h0003);
    chk("mode and pd out", 16'h0003, {14'h0000, lpd, lme});
    wr(CSR, 16'h0000);
    chk("bypass out", 16'h0000, {15'h0000, lme});
    $display("test registers done");
  endtask
  task automatic t_lock;
    @(posedge sys_clk);
    raw <= 1'b1;
    cyc(5);
    rd(CSR, 16'h0060, "lock set");
    wr(CSR, 16'h0008);
    rd(CSR, 16'h0048, "lock in reset");
    wr(CSR, 16'h0000);
    // Lock needs the raw flag low once after a hold before it may rise again.
    raw <= 1'b0;
    cyc(3);
    raw <= 1'b1;
    cyc(5);
    rd(CSR, 16'h0060, "relock");
    wr(CSR, 16'h0002);
    rd(CSR, 16'h0042, "lock in pd");
    wr(CSR, 16'h0000);
    raw <= 1'b0;
    $display("test lock done");
  endtask
  task automatic t_osc;
    wr(CSR, 16'h0004);
    chk("osc request out", 16'h0001, {15'h0000, opc});
    cyc(3);
    chk("osc before idle", 16'h0000, {15'h0000, opd});
    idle <= 1'b1;
    cyc(2);
    chk("osc at idle", 16'h0001, {15'h0000, opd});
    idle <= 1'b0;
    cyc(2);
    rd(CSR, 16'h0004, "stable low");
    tmode <= 1'b1;
    cyc(4);
    rd(CSR, 16'h0044, "test mode");
    tmode <= 1'b0;
    cdis <= 1'b1;
    cyc(4);
    rd(CSR, 16'h0044, "count off");
    cdis <= 1'b0;
    wr(CSR, 16'h0000);
    cyc(2);
    rd(CSR, 16'h0000, "counting");
    cyc(12);
    rd(CSR, 16'h0040, "stable back");
    cms <= 1'b1;
    wr(CSR, 16'h0004);
    // The power-down output is launched on this edge, so look just after it.
    cyc(1);
    #1;
    chk("osc at once", 16'h0001, {15'h0000, opd});
    wr(CSR, 16'h0000);
    cyc(1);
    #1;
    chk("osc running", 16'h0000, {15'h0000, opd});
    $display("test oscillator done");
  endtask
  task automatic t_reprog;
    wr(CSR, 16'h0001);
    chk("pll mode out", 16'h0001, {15'h0000, lme});
    wr(CSR, 16'h0000);
    wr(CSR, 16'h0008);
    chk("loop reset out", 16'h0001, {15'h0000, lrst});
    wr(MUL, 16'h0006);
    chk("new multiplier", 16'h0006, {11'h000, mf});
    // Forty cycles of the 25 ns reference give the settle time before release.
    cyc(40);
    wr(CSR, 16'h0000);
    raw <= 1'b1;
    rd(CSR, 16'h0040, "acquiring");
    cyc(4);
    rd(CSR, 16'h0060, "relocked");
    wr(CSR, 16'h0001);
    rd(CSR, 16'h0061, "back in pll mode");
    raw <= 1'b0;
    $display("test reprogram done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    reset <= 1'b0;
    t_regs;
    t_lock;
    t_osc;
    t_reprog;
    conclude;
  end
  initial begin
    cyc(5000);
    mismatches++;
    conclude;
  end
endmodule // pll_control_status_regs_tb
`default_nettype wire
